// ===== gpio_port_pkg.sv
// constants for the eight-line i/o expander port
// assumes an 8-bit register port driven by the device's serial interface engine
package gpio_port_pkg;

    localparam int LINES = 8;
    typedef logic [LINES-1:0] byte_t;

    // ****************************************
    // register offsets
    // ****************************************
    localparam byte_t PIN_FUNCTION_SELECT_ADDR = 8'h17;
    localparam byte_t LINE_DIRECTION_ADDR = 8'h18;
    localparam byte_t LINE_INPUT_LEVEL_ADDR = 8'h19;
    localparam byte_t LINE_OUTPUT_DRIVE_ADDR = 8'h1a;
    localparam byte_t LINE_INTERRUPT_ENABLE_ADDR = 8'h1b;
    localparam byte_t LINE_IRQ_FLAG_ADDR = 8'h1c;
    localparam byte_t LINE_IRQ_POLARITY_ADDR = 8'h1d;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int COLUMN_FIELD_LSB = 4;
    localparam int COLUMN3_BIT = 7;
    localparam int ROW3_BIT = 3;
    localparam byte_t REG_RESET = 8'h00;
    localparam byte_t UNMAPPED_READ = 8'h00;

endpackage

// ===== input_sync2.sv
// two-flop synchroniser for the asynchronous pin levels
// assumes one clock domain on the consuming side
module input_sync2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire gpio_port_pkg::byte_t async_in,
    output gpio_port_pkg::byte_t sync_out
);
    import gpio_port_pkg::*;

    byte_t meta_ff;
    byte_t level_ff;

    // the first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= REG_RESET;
            level_ff <= REG_RESET;
        end else begin
            meta_ff <= async_in;
            level_ff <= meta_ff;
        end
    end

    assign sync_out = level_ff;

endmodule // input_sync2

// ===== io_expander_gpio_port.sv
// register file, pin drivers and level interrupt of the eight-line i/o expander port
// assumes the serial engine gives one-cycle rd/wr strobes with a stable address
//
// What this block does
// [R01] pin function bits 7..4: clear gives lines 7..4, set gives keypad columns 3..0
// [R02] pin function bits 3..0: clear gives lines 3..0, set gives keypad rows 3..0
// [R03] host sets column-3 pin mode to 1 whenever column pin 3 is used
// [R04] host sets row-3 pin mode to 1 whenever row pin 3 is used
// [R05] direction bit 0 makes line an input, 1 makes it an output
// [R06] input level register returns present level of every line
// [R07] output lines driven to their output drive register bit
// [R08] interrupt enable bit lets a line with its flag set assert the interrupt output
// [R09] interrupt condition is a level; polarity bit picks low or high
// [R10] per-line flag set on condition, cleared after being read twice
// [R11] interrupt output held low while any enabled flag stays set
module io_expander_gpio_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire gpio_port_pkg::byte_t reg_addr,
    input wire gpio_port_pkg::byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output gpio_port_pkg::byte_t reg_rdata,
    input wire logic column3_pin_mode,
    input wire logic row3_pin_mode,
    input wire gpio_port_pkg::byte_t pin_in,
    output gpio_port_pkg::byte_t pin_out,
    output gpio_port_pkg::byte_t pin_oe_n,
    output logic [3:0] keypad_column_en,
    output logic [3:0] keypad_row_en,
    output logic interrupt_request_n
);
    import gpio_port_pkg::*;

    function automatic logic hit(input byte_t addr, input byte_t target);
        return addr == target;
    endfunction

    // ****************************************
    // configuration registers
    // ****************************************
    byte_t function_ff, nxt_function;
    byte_t dir_ff, nxt_dir;
    byte_t out_ff, nxt_out;
    byte_t irq_en_ff, nxt_irq_en;
    byte_t polarity_ff, nxt_polarity;

    always_comb begin
        nxt_function = function_ff;
        nxt_dir = dir_ff;
        nxt_out = out_ff;
        nxt_irq_en = irq_en_ff;
        nxt_polarity = polarity_ff;
        if (reg_wr) begin
            if (hit(reg_addr, PIN_FUNCTION_SELECT_ADDR)) nxt_function = reg_wdata;
            if (hit(reg_addr, LINE_DIRECTION_ADDR)) nxt_dir = reg_wdata;
            if (hit(reg_addr, LINE_OUTPUT_DRIVE_ADDR)) nxt_out = reg_wdata;
            if (hit(reg_addr, LINE_INTERRUPT_ENABLE_ADDR)) nxt_irq_en = reg_wdata;
            if (hit(reg_addr, LINE_IRQ_POLARITY_ADDR)) nxt_polarity = reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            function_ff <= REG_RESET;
            dir_ff <= REG_RESET;
            out_ff <= REG_RESET;
            irq_en_ff <= REG_RESET;
            polarity_ff <= REG_RESET;
        end else begin
            function_ff <= nxt_function;
            dir_ff <= nxt_dir;
            out_ff <= nxt_out;
            irq_en_ff <= nxt_irq_en;
            polarity_ff <= nxt_polarity;
        end
    end

    // ****************************************
    // pin function and drivers
    // ****************************************
    byte_t level_s;
    byte_t gpio_line;
    byte_t nxt_oe_n;
    byte_t oe_n_ff;

    input_sync2 u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(pin_in),
        .sync_out(level_s)
    );

    always_comb begin
        gpio_line = ~function_ff; // R01 R02
        // pins 7 and 3 are dead unless their pad mode is set
        gpio_line[COLUMN3_BIT] = ~function_ff[COLUMN3_BIT] & column3_pin_mode; // R03
        gpio_line[ROW3_BIT] = ~function_ff[ROW3_BIT] & row3_pin_mode; // R04
        nxt_oe_n = ~(gpio_line & dir_ff); // R05
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_n_ff <= ~REG_RESET;
        end else begin
            oe_n_ff <= nxt_oe_n;
        end
    end

    assign pin_oe_n = oe_n_ff;
    assign pin_out = out_ff; // R07
    assign keypad_column_en = function_ff[LINES-1:COLUMN_FIELD_LSB]; // R01
    assign keypad_row_en = function_ff[COLUMN_FIELD_LSB-1:0]; // R02

    // ****************************************
    // interrupt flags and output
    // ****************************************
    byte_t flag_ff, nxt_flag;
    byte_t seen_ff, nxt_seen;
    byte_t cond;
    logic irq_n_ff, nxt_irq_n;
    logic rd_flag;
    logic [1:0] primed_ff, nxt_primed;

    always_comb begin
        rd_flag = reg_rd && hit(reg_addr, LINE_IRQ_FLAG_ADDR);
        // synchroniser shows reset zeros for two edges, not real pin levels
        nxt_primed = {primed_ff[0], 1'b1};
        // only lines that are general-purpose inputs can raise a condition
        cond = {LINES{primed_ff[1]}} & gpio_line & ~dir_ff & ~(level_s ^ polarity_ff); // R09
        for (int i = 0; i < LINES; i++) begin
            // a live condition wins over the second read
            nxt_flag[i] = cond[i] | (flag_ff[i] & ~(rd_flag & seen_ff[i])); // R10
            nxt_seen[i] = nxt_flag[i] & ((rd_flag & flag_ff[i]) ? ~seen_ff[i] : seen_ff[i]);
        end
        nxt_irq_n = ~|(flag_ff & irq_en_ff); // R08 R11
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_ff <= REG_RESET;
            seen_ff <= REG_RESET;
            irq_n_ff <= 1'b1;
            primed_ff <= 2'h0;
        end else begin
            flag_ff <= nxt_flag;
            seen_ff <= nxt_seen;
            irq_n_ff <= nxt_irq_n;
            primed_ff <= nxt_primed;
        end
    end

    assign interrupt_request_n = irq_n_ff;

    // ****************************************
    // read data
    // ****************************************
    byte_t rdata_ff, nxt_rdata;

    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            unique case (reg_addr)
                PIN_FUNCTION_SELECT_ADDR: nxt_rdata = function_ff;
                LINE_DIRECTION_ADDR: nxt_rdata = dir_ff;
                LINE_INPUT_LEVEL_ADDR: nxt_rdata = level_s; // R06
                LINE_OUTPUT_DRIVE_ADDR: nxt_rdata = out_ff;
                LINE_INTERRUPT_ENABLE_ADDR: nxt_rdata = irq_en_ff;
                LINE_IRQ_FLAG_ADDR: nxt_rdata = flag_ff;
                LINE_IRQ_POLARITY_ADDR: nxt_rdata = polarity_ff;
                default: nxt_rdata = UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= REG_RESET;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_first_read;
        rd_flag && flag_ff[0] && !seen_ff[0] && !cond[0];
    endsequence

    sequence s_second_read;
        rd_flag && flag_ff[0] && seen_ff[0] && !cond[0];
    endsequence

    a_column_keypad_release: assert property ( // R01
        reg_wr && hit(reg_addr, PIN_FUNCTION_SELECT_ADDR) |=> ##1
        ((pin_oe_n[LINES-1:COLUMN_FIELD_LSB] | ~keypad_column_en) == 4'hf))
        else $error("keypad column pin still driven");
    a_row_keypad_release: assert property ( // R02
        reg_wr && hit(reg_addr, PIN_FUNCTION_SELECT_ADDR) |=> ##1
        ((pin_oe_n[COLUMN_FIELD_LSB-1:0] | ~keypad_row_en) == 4'hf))
        else $error("keypad row pin still driven");
    a_direction_drive: assert property ( // R05
        pin_oe_n == ~$past(gpio_line & dir_ff))
        else $error("pin enable does not follow direction");
    a_level_readback: assert property ( // R06
        reg_rd && hit(reg_addr, LINE_INPUT_LEVEL_ADDR) |=> reg_rdata == $past(level_s))
        else $error("input level readback wrong");
    a_output_value: assert property ( // R07
        reg_wr && hit(reg_addr, LINE_OUTPUT_DRIVE_ADDR) |=> pin_out == $past(reg_wdata))
        else $error("output drive not applied");
    a_irq_masked: assert property ( // R08
        (flag_ff & irq_en_ff) == REG_RESET |=> interrupt_request_n)
        else $error("interrupt raised by masked line");
    a_level_sets_flag: assert property ( // R09
        cond != REG_RESET |=> (flag_ff & $past(cond)) == $past(cond))
        else $error("level condition did not set flag");
    a_one_read_keeps: assert property ( // R10
        s_first_read |=> flag_ff[0])
        else $error("flag cleared by a single read");
    a_two_reads_clear: assert property ( // R10
        s_first_read ##[1:20] s_second_read |=> !flag_ff[0])
        else $error("flag not cleared by second read");
    a_irq_held: assert property ( // R11
        (flag_ff & irq_en_ff) != REG_RESET |=> !interrupt_request_n)
        else $error("interrupt output not asserted");

endmodule // io_expander_gpio_port

// ===== pad_model.sv
// pad model: resolves each pad from the port's enable and the board's own drive
// assumes pads not driven by the port follow the bench's external level
module pad_model (
    input wire gpio_port_pkg::byte_t pin_out,
    input wire gpio_port_pkg::byte_t pin_oe_n,
    input wire gpio_port_pkg::byte_t ext_level,
    output gpio_port_pkg::byte_t pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    import gpio_port_pkg::*;
    // a driving port wins over the board, as on a real pad
    assign pin_level = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule // pad_model

// ===== testbench.sv
// self-checking bench for the i/o expander port
// assumes the register strobe port and the pad model beside it
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import gpio_port_pkg::*;
    logic clk, rst_n, reg_wr, reg_rd, column3_pin_mode, row3_pin_mode, interrupt_request_n;
    byte_t reg_addr, reg_wdata, reg_rdata, pin_in, pin_out, pin_oe_n, ext_level, f, d, o, m, v;
    logic [3:0] keypad_column_en, keypad_row_en;
    int bad_count, checks_done, cycles, seed;
    io_expander_gpio_port uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .column3_pin_mode(column3_pin_mode), .row3_pin_mode(row3_pin_mode), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .keypad_column_en(keypad_column_en),
        .keypad_row_en(keypad_row_en), .interrupt_request_n(interrupt_request_n));
    pad_model pads (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level),
        .pin_level(pin_in));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ****************************************
    // helpers
    // ****************************************
    function automatic byte_t drive_mask(byte_t fn, byte_t dir, logic c3, logic r3);
        byte_t r;
        r = ~fn & dir;
        r[COLUMN3_BIT] = r[COLUMN3_BIT] & c3;
        r[ROW3_BIT] = r[ROW3_BIT] & r3;
        return r;
    endfunction
    task automatic chk(input string name, input byte_t seen, input byte_t exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input byte_t a, input byte_t x);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = x;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input byte_t a, output byte_t x);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        x = reg_rdata;
    endtask
    task automatic rd_chk(input string name, input byte_t a, input byte_t exp);
        byte_t x;
        rd(a, x);
        chk(name, x, exp);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            $display("mismatch timeout expected 0 seen 1");
            give_verdict();
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        seed = 11651;
        {bad_count, checks_done, cycles} = '0;
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        column3_pin_mode = 1'b1;
        row3_pin_mode = 1'b1;
        ext_level = 8'hff;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        for (int a = 8'h17; a <= 8'h1d; a++) begin
            rd_chk("reset", byte_t'(a), (a == 8'h19) ? 8'hff : REG_RESET);
        end
        rd_chk("unmapped", 8'h30, UNMAPPED_READ);
        for (int i = 0; i < 12; i++) begin
            {f, d, o, ext_level} = {$random(seed)};
            // last pass: pin modes off, pins 7 and 3 must go quiet
            column3_pin_mode = (i != 11);
            row3_pin_mode = (i != 11);
            wr(PIN_FUNCTION_SELECT_ADDR, f);
            wr(LINE_DIRECTION_ADDR, d);
            wr(LINE_OUTPUT_DRIVE_ADDR, o);
            wr(LINE_INPUT_LEVEL_ADDR, ~o);
            wr(8'h30, o);
            repeat (3) @(negedge clk);
            m = drive_mask(f, d, column3_pin_mode, row3_pin_mode);
            chk("column_en", {4'h0, keypad_column_en}, {4'h0, f[7:4]});
            chk("row_en", {4'h0, keypad_row_en}, {4'h0, f[3:0]});
            chk("pin_oe_n", pin_oe_n, ~m);
            chk("pin_out", pin_out, o);
            chk("irq_n", {7'h0, interrupt_request_n}, 8'h01);
            rd_chk("function", PIN_FUNCTION_SELECT_ADDR, f);
            rd_chk("direction", LINE_DIRECTION_ADDR, d);
            rd_chk("level", LINE_INPUT_LEVEL_ADDR, (o & m) | (ext_level & ~m));
        end
        {column3_pin_mode, row3_pin_mode, ext_level} = {2'b11, 8'hff};
        wr(PIN_FUNCTION_SELECT_ADDR, 8'h00);
        wr(LINE_DIRECTION_ADDR, 8'h00);
        repeat (3) @(negedge clk);
        rd(LINE_IRQ_FLAG_ADDR, v);
        rd(LINE_IRQ_FLAG_ADDR, v);
        rd_chk("flag_clear", LINE_IRQ_FLAG_ADDR, 8'h00);
        wr(LINE_INTERRUPT_ENABLE_ADDR, 8'h01);
        wr(LINE_IRQ_POLARITY_ADDR, 8'h04);
        ext_level = 8'hfe;
        repeat (5) @(negedge clk);
        chk("irq_n_low", {7'h0, interrupt_request_n}, 8'h00);
        rd_chk("flag_set", LINE_IRQ_FLAG_ADDR, 8'h05);
        rd_chk("flag_held", LINE_IRQ_FLAG_ADDR, 8'h05);
        rd_chk("flag_held", LINE_IRQ_FLAG_ADDR, 8'h05);
        ext_level = 8'hfb;
        repeat (3) @(negedge clk);
        chk("irq_n_held", {7'h0, interrupt_request_n}, 8'h00);
        rd_chk("flag_arm", LINE_IRQ_FLAG_ADDR, 8'h05);
        rd(LINE_IRQ_FLAG_ADDR, v);
        rd_chk("flag_gone", LINE_IRQ_FLAG_ADDR, 8'h00);
        chk("irq_n_free", {7'h0, interrupt_request_n}, 8'h01);
        wr(LINE_INTERRUPT_ENABLE_ADDR, 8'h00);
        ext_level = 8'hfe;
        repeat (5) @(negedge clk);
        chk("irq_n_masked", {7'h0, interrupt_request_n}, 8'h01);
        rd_chk("flag_masked", LINE_IRQ_FLAG_ADDR, 8'h05);
        rd(LINE_IRQ_FLAG_ADDR, v);
        ext_level = 8'hfb;
        repeat (3) @(negedge clk);
        rd_chk("flag_one_read", LINE_IRQ_FLAG_ADDR, 8'h05);
        rd_chk("flag_two_reads", LINE_IRQ_FLAG_ADDR, 8'h05);
        rd_chk("flag_cleared", LINE_IRQ_FLAG_ADDR, 8'h00);
        chk("irq_n_quiet", {7'h0, interrupt_request_n}, 8'h01);
        give_verdict();
    end
endmodule // testbench
